// >>> dv/spc_lp_model.sv
// Link partner model: negotiation answers, receive frames and collision reports
`timescale 1ns/1ns
module spc_lp_model
  import spc_pkg::*;
(
  // Clock
  input  wire logic mclk,
  // Negotiation
  output logic      an_done,
  output logic      lp_pause,
  // Receive stream towards the port
  output logic      rx_valid,
  output spc_beat_t rx_beat,
  // Collision reports
  output logic      tx_col
);

  initial begin
    an_done  = 1'b0;
    lp_pause = 1'b0;
    rx_valid = 1'b0;
    rx_beat  = '0;
    tx_col   = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic negotiate(input logic ab);
    @(posedge mclk);
    an_done  <= 1'b1;
    lp_pause <= ab;
    @(posedge mclk);
    an_done  <= 1'b0;
  endtask

  // Byte i carries i[7:0]; gap idles between bytes to mimic a slow sender
  task automatic send_frame(input int n, input int gap);
    for (int i = 0; i < n; i++) begin
      if (gap > 0 && i > 0) begin
        @(posedge mclk);
        rx_valid <= 1'b0;
        repeat (gap - 1) @(posedge mclk);
      end
      @(posedge mclk);
      rx_valid <= 1'b1;
      rx_beat  <= {i[7:0], i == n - 1};
    end
    @(posedge mclk);
    rx_valid <= 1'b0;
    // Idle bus carries a changed byte so a stale value cannot pass as data
    rx_beat  <= {~rx_beat.data, 1'b0};
  endtask

  task automatic collide(input int n);
    for (int i = 0; i < n; i++) begin
      @(posedge mclk);
      tx_col <= 1'b1;
    end
    @(posedge mclk);
    tx_col <= 1'b0;
  endtask

endmodule

// >>> dv/tb_top.sv
// Self-checking bench for the switch port MAC settings block
`timescale 1ns/1ns
`define CHK(nm, ex, got) begin check_count++; if ((got) !== (ex)) begin n_fail++; \
  $display("unexpected %s exp=%0h got=%0h", nm, ex, got); end end
module tb_top;
  import spc_pkg::*;

  typedef struct {
    logic [3:0] ctrl;
    logic [5:0] sel;
    logic       lp;
    logic [5:0] adv;
    logic       ap;
    logic       chk_ap;
    logic       rx;
    logic       tx;
  } spc_row_t;

  logic                  mclk;
  logic                  rst;
  logic [SPC_AW-1:0]     reg_addr;
  logic [SPC_DW-1:0]     reg_wdata;
  logic [SPC_DW-1:0]     reg_rdata;
  logic [SPC_DW-1:0]     rd;
  logic                  reg_wr;
  logic                  reg_rd;
  logic [SPC_SPD_W-1:0]  adv_speed;
  logic                  adv_pause;
  logic                  an_done;
  logic                  lp_pause;
  logic                  pause_rx_en;
  logic                  pause_tx_en;
  logic [SPC_PRIO_W-1:0] pfc_prio_en;
  logic                  rx_valid;
  logic                  fwd_valid;
  logic                  rx_oversize;
  logic                  tx_start;
  logic                  tx_col;
  logic                  tx_abandon;
  spc_beat_t             rx_beat;
  spc_beat_t             fwd_beat;
  int                    n_fail;
  int                    check_count;
  int                    fwd_cnt;
  int                    ovr_cnt;
  int                    abn_cnt;
  // ctrl, select, partner pause, adv speed, adv pause, check adv pause, rx, tx
  spc_row_t rows [6] = '{
    '{4'h3, 6'h00, 1'b1, 6'h3f, 1'b1, 1'b1, 1'b1, 1'b1},
    '{4'h3, 6'h05, 1'b0, 6'h05, 1'b1, 1'b1, 1'b0, 1'b0},
    '{4'h1, 6'h12, 1'b1, 6'h12, 1'b0, 1'b1, 1'b0, 1'b0},
    '{4'h2, 6'h05, 1'b0, 6'h00, 1'b0, 1'b1, 1'b1, 1'b1},
    '{4'h7, 6'h00, 1'b1, 6'h3f, 1'b1, 1'b1, 1'b0, 1'b0},
    '{4'h5, 6'h00, 1'b1, 6'h3f, 1'b0, 1'b1, 1'b0, 1'b0}};

  spc_port_cfg DUT (.mclk(mclk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .adv_speed(adv_speed), .adv_pause(adv_pause), .an_done(an_done),
    .lp_pause(lp_pause), .pause_rx_en(pause_rx_en), .pause_tx_en(pause_tx_en), .pfc_prio_en(pfc_prio_en),
    .rx_valid(rx_valid), .rx_beat(rx_beat), .fwd_valid(fwd_valid), .fwd_beat(fwd_beat),
    .rx_oversize(rx_oversize), .tx_start(tx_start), .tx_col(tx_col), .tx_abandon(tx_abandon));

  spc_lp_model LP (.mclk(mclk), .an_done(an_done), .lp_pause(lp_pause), .rx_valid(rx_valid),
    .rx_beat(rx_beat), .tx_col(tx_col));

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    mclk = 1'b0;
  end
  always #20 mclk = ~mclk;

  always @(posedge mclk) begin
    if (fwd_valid === 1'b1) begin
      // Forwarded bytes are always the head of a frame, so the data counts up
      `CHK("fwd_data", 8'(fwd_cnt), fwd_beat.data)
      fwd_cnt++;
    end
    if (rx_oversize === 1'b1) begin
      ovr_cnt++;
      `CHK("cut_last", 1'b1, fwd_beat.last)
    end
    if (tx_abandon === 1'b1) begin
      abn_cnt++;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic conclude();
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic wr(input logic [SPC_AW-1:0] a, input logic [SPC_DW-1:0] d);
    @(posedge mclk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge mclk);
    reg_wr    <= 1'b0;
  endtask

  task automatic rchk(input logic [SPC_AW-1:0] a, input logic [SPC_DW-1:0] ex, input string nm);
    @(posedge mclk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge mclk);
    reg_rd   <= 1'b0;
    #1;
    rd = reg_rdata;
    `CHK(nm, ex, rd)
  endtask

  // Counts are zeroed off the edge so the monitor never races the reset of them
  task automatic run_frame(input int n, input int gap, input int exp_fwd, input int exp_ovr);
    #1;
    fwd_cnt = 0;
    ovr_cnt = 0;
    LP.send_frame(n, gap);
    repeat (3) @(posedge mclk);
    #1;
    `CHK("fwd_count", exp_fwd, fwd_cnt)
    `CHK("ovr_count", exp_ovr, ovr_cnt)
  endtask

  task automatic run_coll(input logic mode, input int n, input int ex);
    #1;
    abn_cnt = 0;
    wr(SPC_OFS_CTRL, {28'h0, mode, 3'h1});
    @(posedge mclk);
    tx_start <= 1'b1;
    @(posedge mclk);
    tx_start <= 1'b0;
    LP.collide(n);
    repeat (3) @(posedge mclk);
    #1;
    `CHK("abandon_count", ex, abn_cnt)
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    rst = 1'b1;
    reg_addr = '0;
    reg_wdata = '0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    tx_start = 1'b0;
    n_fail = 0;
    check_count = 0;
    fwd_cnt = 0;
    ovr_cnt = 0;
    abn_cnt = 0;
    repeat (8) @(posedge mclk);
    rst <= 1'b0;
    #1;
    `CHK("adv_speed_rst", SPC_SPD_ALL, adv_speed)
    `CHK("pause_rx_rst", 1'b0, pause_rx_en)
    rchk(SPC_OFS_CTRL, 32'h1, "ctrl_rst");
    rchk(SPC_OFS_MAXLEN, 32'd1518, "maxlen_rst");
    rchk(SPC_OFS_STATUS, 32'h0, "status_rst");
    rchk(4'h2, 32'h0, "unmapped");
    wr(SPC_OFS_PRIO, 32'h8f);
    foreach (rows[i]) begin
      wr(SPC_OFS_CTRL, {28'h0, rows[i].ctrl});
      wr(SPC_OFS_ADV_SPD, {26'h0, rows[i].sel});
      LP.negotiate(rows[i].lp);
      @(posedge mclk);
      #1;
      `CHK("adv_speed", rows[i].adv, adv_speed)
      if (rows[i].chk_ap) begin
        `CHK("adv_pause", rows[i].ap, adv_pause)
      end
      `CHK("pause_rx_en", rows[i].rx, pause_rx_en)
      `CHK("pause_tx_en", rows[i].tx, pause_tx_en)
      `CHK("pfc_prio_en", rows[i].ctrl[2] ? 8'h8f : 8'h00, pfc_prio_en)
      rchk(SPC_OFS_STATUS, {28'h0, 1'b1, rows[i].ctrl[2], rows[i].tx, rows[i].rx}, "status");
    end
    run_frame(1518, 1, 1518, 0);
    run_frame(1519, 0, 1519, 1);
    run_frame(1522, 0, 1519, 1);
    rchk(SPC_OFS_STATUS, 32'h0002000c, "oversize_count");
    wr(SPC_OFS_MAXLEN, 32'd20);
    rchk(SPC_OFS_MAXLEN, 32'd1518, "maxlen_low");
    wr(SPC_OFS_MAXLEN, 32'h3fff);
    rchk(SPC_OFS_MAXLEN, 32'd10056, "maxlen_high");
    // One frame covers both sides of the upper limit
    run_frame(10057, 0, 10057, 1);
    run_coll(1'b0, 15, 0);
    run_coll(1'b0, 16, 1);
    run_coll(1'b1, 20, 0);
    conclude();
  end

  // The tests need about 16300 cycles; nearly four times that means a hang
  initial begin
    repeat (63000) @(posedge mclk);
    n_fail++;
    $display("unexpected watchdog exp=done got=hang");
    conclude();
  end

endmodule

// >>> rtl/spc_coll.sv
// Collision counter that abandons a half-duplex frame after the collision limit
`timescale 1ns/1ns
module spc_coll
  import spc_pkg::*;
#(
  parameter logic [4:0] LIMIT = SPC_COLL_LIMIT
) (
  // Clock and reset
  input  wire logic       mclk,
  input  wire logic       rst,
  // Transmit attempt
  input  wire logic       tx_start,
  input  wire logic       tx_col,
  input  wire logic       retry_mode,
  // Result
  output logic            tx_abandon,
  output logic [4:0]      col_cnt
);

  logic [4:0] cnt_reg;
  logic       abandon_reg;
  logic       hit_next;

  // The limit counts the collision just seen, so the 16th one abandons
  assign hit_next = tx_col && !retry_mode && (cnt_reg + 5'h01 == LIMIT);

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      cnt_reg <= 5'h00;
    end else if (tx_start || hit_next) begin
      cnt_reg <= 5'h00;
    end else if (tx_col && cnt_reg != LIMIT) begin
      cnt_reg <= cnt_reg + 5'h01;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      abandon_reg <= 1'b0;
    end else begin
      abandon_reg <= hit_next; // see [R12]
    end
  end

  assign tx_abandon = abandon_reg;
  assign col_cnt    = cnt_reg;

  property p_coll_drop;
    @(posedge mclk) disable iff (rst)
      (tx_col && !tx_start && !retry_mode && cnt_reg == (LIMIT - 5'h01)) |=> tx_abandon && cnt_reg == 5'h00;
  endproperty
  a_coll_drop: assert property (p_coll_drop) else $error("frame not dropped at 16 collisions"); // see [R12]

  property p_coll_early;
    @(posedge mclk) disable iff (rst)
      (cnt_reg < (LIMIT - 5'h01)) |=> !tx_abandon;
  endproperty
  a_coll_early: assert property (p_coll_early) else $error("frame dropped before 16 collisions"); // see [R12]

endmodule

// >>> rtl/spc_pkg.sv
// Package of constants and carrier types for the switch port MAC settings block
// Summary of operation
// [R01] Auto speed advertises only the selected speeds
// [R02] Empty speed selection advertises all supported speeds
// [R03] Auto speed advertises configured pause capability
// [R04] Fixed speed applies configured pause directly
// [R05] Status shows whether received pause is obeyed
// [R06] Status shows whether pause frames are sent
// [R07] Auto mode pause follows last negotiation result
// [R08] Priority flow control pauses only selected priorities
// [R09] Priority flow control never advertised or negotiated
// [R10] Priority and ordinary pause never both active
// [R11] Maximum frame length 1518 to 10056, FCS included
// [R12] Default mode drops frame after 16 collisions
// [R13] Oversize received frames dropped and counted; the code forwards bytes up to the first one past the limit
package spc_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Widths
  localparam int SPC_AW        = 4;
  localparam int SPC_DW        = 32;
  localparam int SPC_SPD_W     = 6;
  localparam int SPC_PRIO_W    = 8;
  localparam int SPC_LEN_W     = 14;
  localparam int SPC_CNT_W     = 16;

  ////////////////////////////////////////////////////////////////////////////
  // Register offsets (byte addresses)
  localparam logic [SPC_AW-1:0] SPC_OFS_CTRL    = 4'h0;
  localparam logic [SPC_AW-1:0] SPC_OFS_ADV_SPD = 4'h4;
  localparam logic [SPC_AW-1:0] SPC_OFS_PRIO    = 4'h8;
  localparam logic [SPC_AW-1:0] SPC_OFS_MAXLEN  = 4'hc;
  localparam logic [SPC_AW-1:0] SPC_OFS_STATUS  = 4'h1;

  ////////////////////////////////////////////////////////////////////////////
  // Control register fields
  localparam int SPC_CTRL_AUTO  = 0;
  localparam int SPC_CTRL_FC    = 1;
  localparam int SPC_CTRL_PFC   = 2;
  localparam int SPC_CTRL_COLL  = 3;

  // Status register fields (read at the status word)
  localparam int SPC_ST_RX      = 0;
  localparam int SPC_ST_TX      = 1;
  localparam int SPC_ST_PFC     = 2;
  localparam int SPC_ST_AN      = 3;
  localparam int SPC_ST_OVR_LSB = 16;

  ////////////////////////////////////////////////////////////////////////////
  // Reset values and limits
  localparam logic [SPC_SPD_W-1:0] SPC_SPD_ALL    = 6'h3f;
  localparam logic [SPC_LEN_W-1:0] SPC_LEN_MIN    = 14'd1518;
  localparam logic [SPC_LEN_W-1:0] SPC_LEN_MAX    = 14'd10056;
  localparam logic [4:0]           SPC_COLL_LIMIT = 5'h10;

  ////////////////////////////////////////////////////////////////////////////
  // Carriers
  typedef struct packed {
    logic [7:0] data;
    logic       last;
  } spc_beat_t;

  typedef struct packed {
    logic auto_spd;
    logic fc_en;
    logic pfc_en;
    logic coll_retry;
  } spc_ctrl_t;

  typedef enum logic [1:0] {
    SPC_RX_IDLE = 2'b00,
    SPC_RX_PASS = 2'b01,
    SPC_RX_DROP = 2'b10
  } spc_rx_state_t;

endpackage

// >>> rtl/spc_port_cfg.sv
// Per-port MAC settings: advertisement, pause resolution, frame length and collisions
`timescale 1ns/1ns
module spc_port_cfg
  import spc_pkg::*;
#(
  parameter logic [SPC_SPD_W-1:0] SUPPORTED = SPC_SPD_ALL
) (
  // Clock and reset
  input  wire logic                  mclk,
  input  wire logic                  rst,
  // Register port
  input  wire logic [SPC_AW-1:0]     reg_addr,
  input  wire logic [SPC_DW-1:0]     reg_wdata,
  input  wire logic                  reg_wr,
  input  wire logic                  reg_rd,
  output logic [SPC_DW-1:0]          reg_rdata,
  // Auto-negotiation
  output logic [SPC_SPD_W-1:0]       adv_speed,
  output logic                       adv_pause,
  input  wire logic                  an_done,
  input  wire logic                  lp_pause,
  // Active flow control
  output logic                       pause_rx_en,
  output logic                       pause_tx_en,
  output logic [SPC_PRIO_W-1:0]      pfc_prio_en,
  // Receive stream
  input  wire logic                  rx_valid,
  input  wire spc_beat_t             rx_beat,
  output logic                       fwd_valid,
  output spc_beat_t                  fwd_beat,
  output logic                       rx_oversize,
  // Transmit collisions
  input  wire logic                  tx_start,
  input  wire logic                  tx_col,
  output logic                       tx_abandon
);

  ////////////////////////////////////////////////////////////////////////////
  // Register storage
  spc_ctrl_t                ctrl_reg;
  logic [SPC_SPD_W-1:0]     adv_spd_reg;
  logic [SPC_PRIO_W-1:0]    prio_reg;
  logic [SPC_LEN_W-1:0]     maxlen_reg;
  logic [SPC_DW-1:0]        rdata_reg;
  logic                     an_ok_reg;
  logic                     an_rx_reg;
  logic                     an_tx_reg;
  logic [SPC_CNT_W-1:0]     ovr_cnt_reg;
  logic [SPC_LEN_W-1:0]     wlen;
  logic [SPC_LEN_W-1:0]     clamp_len;

  function automatic logic hit(input logic [SPC_AW-1:0] a, input logic [SPC_AW-1:0] ofs);
    hit = (a == ofs);
  endfunction

  // Out-of-range lengths are pinned to the nearest legal bound
  assign wlen      = reg_wdata[SPC_LEN_W-1:0];
  assign clamp_len = (reg_wdata[SPC_DW-1:SPC_LEN_W] != '0 || wlen > SPC_LEN_MAX) ? SPC_LEN_MAX :
                     (wlen < SPC_LEN_MIN) ? SPC_LEN_MIN : wlen;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      ctrl_reg <= '{auto_spd: 1'b1, fc_en: 1'b0, pfc_en: 1'b0, coll_retry: 1'b0};
    end else if (reg_wr && hit(reg_addr, SPC_OFS_CTRL)) begin
      ctrl_reg.auto_spd   <= reg_wdata[SPC_CTRL_AUTO];
      ctrl_reg.fc_en      <= reg_wdata[SPC_CTRL_FC];
      ctrl_reg.pfc_en     <= reg_wdata[SPC_CTRL_PFC];
      ctrl_reg.coll_retry <= reg_wdata[SPC_CTRL_COLL];
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      adv_spd_reg <= '0;
    end else if (reg_wr && hit(reg_addr, SPC_OFS_ADV_SPD)) begin
      adv_spd_reg <= reg_wdata[SPC_SPD_W-1:0];
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      prio_reg <= '0;
    end else if (reg_wr && hit(reg_addr, SPC_OFS_PRIO)) begin
      prio_reg <= reg_wdata[SPC_PRIO_W-1:0];
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      maxlen_reg <= SPC_LEN_MIN;
    end else if (reg_wr && hit(reg_addr, SPC_OFS_MAXLEN)) begin
      maxlen_reg <= clamp_len; // see [R11]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Advertisement
  always_comb begin
    if (!ctrl_reg.auto_spd) begin
      adv_speed = '0;
    end else if (adv_spd_reg == '0) begin
      adv_speed = SUPPORTED; // see [R02]
    end else begin
      adv_speed = adv_spd_reg & SUPPORTED; // see [R01]
    end
  end

  // Priority flow control has no advertisement bit at all
  assign adv_pause = ctrl_reg.auto_spd && ctrl_reg.fc_en; // see [R03] see [R09]

  ////////////////////////////////////////////////////////////////////////////
  // Negotiation result, latched on each completed exchange
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      an_ok_reg <= 1'b0;
      an_rx_reg <= 1'b0;
      an_tx_reg <= 1'b0;
    end else if (an_done) begin
      an_ok_reg <= 1'b1;
      an_rx_reg <= adv_pause && lp_pause; // see [R07]
      an_tx_reg <= adv_pause && lp_pause; // see [R07]
    end
  end

  // Priority flow control wins, so the two schemes never overlap
  always_comb begin
    if (ctrl_reg.pfc_en) begin
      pause_rx_en = 1'b0; // see [R10]
      pause_tx_en = 1'b0; // see [R10]
    end else if (ctrl_reg.auto_spd) begin
      pause_rx_en = an_ok_reg && an_rx_reg; // see [R07]
      pause_tx_en = an_ok_reg && an_tx_reg; // see [R07]
    end else begin
      pause_rx_en = ctrl_reg.fc_en; // see [R04]
      pause_tx_en = ctrl_reg.fc_en; // see [R04]
    end
  end

  assign pfc_prio_en = ctrl_reg.pfc_en ? prio_reg : '0; // see [R08]

  ////////////////////////////////////////////////////////////////////////////
  // Receive length check
  spc_rx_state_t            rx_state_reg;
  spc_rx_state_t            rx_state_next;
  logic [SPC_LEN_W-1:0]     rx_len_reg;
  logic [SPC_LEN_W-1:0]     rx_len_next;
  logic                     over_now;
  logic                     fwd_valid_reg;
  spc_beat_t                fwd_beat_reg;
  logic                     ovr_reg;

  // Byte count of this beat, saturating just above the top legal length
  assign rx_len_next = (rx_state_reg == SPC_RX_IDLE) ? 14'd1 :
                       (rx_len_reg > SPC_LEN_MAX) ? rx_len_reg : rx_len_reg + 14'd1;
  assign over_now    = rx_valid && (rx_len_next > maxlen_reg);

  always_comb begin
    rx_state_next = rx_state_reg;
    if (rx_valid) begin
      unique case (rx_state_reg)
        SPC_RX_IDLE, SPC_RX_PASS: begin
          if (rx_beat.last) begin
            rx_state_next = SPC_RX_IDLE;
          end else if (over_now) begin
            rx_state_next = SPC_RX_DROP;
          end else begin
            rx_state_next = SPC_RX_PASS;
          end
        end
        SPC_RX_DROP: begin
          if (rx_beat.last) begin
            rx_state_next = SPC_RX_IDLE;
          end
        end
        default: begin
          rx_state_next = SPC_RX_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      rx_state_reg <= SPC_RX_IDLE;
      rx_len_reg   <= '0;
    end else begin
      rx_state_reg <= rx_state_next;
      if (rx_valid) begin
        rx_len_reg <= rx_len_next;
      end
    end
  end

  // The frame is cut at the first byte past the limit; downstream sees an
  // aborted frame whose last beat carries the oversize flag
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      fwd_valid_reg <= 1'b0;
      fwd_beat_reg  <= '0;
      ovr_reg       <= 1'b0;
    end else begin
      fwd_valid_reg <= 1'b0;
      ovr_reg       <= 1'b0;
      if (rx_valid && rx_state_reg != SPC_RX_DROP) begin
        fwd_valid_reg     <= 1'b1;
        fwd_beat_reg.data <= rx_beat.data;
        fwd_beat_reg.last <= rx_beat.last || over_now;
        ovr_reg           <= over_now; // see [R13]
      end
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      ovr_cnt_reg <= '0;
    end else if (rx_valid && rx_state_reg != SPC_RX_DROP && over_now && ovr_cnt_reg != '1) begin
      ovr_cnt_reg <= ovr_cnt_reg + 16'h0001; // see [R13]
    end
  end

  assign fwd_valid   = fwd_valid_reg;
  assign fwd_beat    = fwd_beat_reg;
  assign rx_oversize = ovr_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Collision handling
  spc_coll u_coll (
    .mclk       (mclk),
    .rst        (rst),
    .tx_start   (tx_start),
    .tx_col     (tx_col),
    .retry_mode (ctrl_reg.coll_retry),
    .tx_abandon (tx_abandon),
    .col_cnt    ()
  );

  ////////////////////////////////////////////////////////////////////////////
  // Read path
  logic [SPC_DW-1:0] status_word;

  assign status_word = {ovr_cnt_reg, 12'h000, an_ok_reg, ctrl_reg.pfc_en,
                        pause_tx_en, pause_rx_en}; // see [R05] see [R06]

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      rdata_reg <= '0;
    end else if (reg_rd) begin
      unique case (reg_addr)
        SPC_OFS_CTRL:    rdata_reg <= {28'h0000000, ctrl_reg.coll_retry, ctrl_reg.pfc_en,
                                       ctrl_reg.fc_en, ctrl_reg.auto_spd};
        SPC_OFS_ADV_SPD: rdata_reg <= {26'h0000000, adv_spd_reg};
        SPC_OFS_PRIO:    rdata_reg <= {24'h000000, prio_reg};
        SPC_OFS_MAXLEN:  rdata_reg <= {18'h00000, maxlen_reg};
        SPC_OFS_STATUS:  rdata_reg <= status_word;
        default:         rdata_reg <= '0;
      endcase
    end else begin
      rdata_reg <= '0;
    end
  end

  assign reg_rdata = rdata_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  property p_adv_sel;
    @(posedge mclk) disable iff (rst)
      (ctrl_reg.auto_spd && adv_spd_reg != '0) |-> (adv_speed == (adv_spd_reg & SUPPORTED));
  endproperty
  a_adv_sel: assert property (p_adv_sel) else $error("advertised speeds differ from selection"); // see [R01]

  property p_adv_all;
    @(posedge mclk) disable iff (rst)
      (ctrl_reg.auto_spd && adv_spd_reg == '0) |-> (adv_speed == SUPPORTED);
  endproperty
  a_adv_all: assert property (p_adv_all) else $error("empty selection must advertise all speeds"); // see [R02]

  property p_adv_pause;
    @(posedge mclk) disable iff (rst)
      ctrl_reg.auto_spd |-> (adv_pause == ctrl_reg.fc_en);
  endproperty
  a_adv_pause: assert property (p_adv_pause) else $error("advertised pause differs from setting"); // see [R03]

  property p_fixed_fc;
    @(posedge mclk) disable iff (rst)
      (!ctrl_reg.auto_spd && !ctrl_reg.pfc_en) |-> (pause_rx_en == ctrl_reg.fc_en && pause_tx_en == ctrl_reg.fc_en);
  endproperty
  a_fixed_fc: assert property (p_fixed_fc) else $error("fixed speed pause not from setting"); // see [R04]

  property p_an_result;
    @(posedge mclk) disable iff (rst)
      (an_done && adv_pause && !lp_pause) ##1 (ctrl_reg.auto_spd && !an_done) |-> !pause_rx_en && !pause_tx_en;
  endproperty
  a_an_result: assert property (p_an_result) else $error("pause active against negotiation result"); // see [R07]

  property p_exclusive;
    @(posedge mclk) disable iff (rst)
      (pfc_prio_en != '0) |-> !pause_rx_en && !pause_tx_en;
  endproperty
  a_exclusive: assert property (p_exclusive) else $error("priority and ordinary pause both active"); // see [R10]

  property p_status;
    @(posedge mclk) disable iff (rst)
      (reg_rd && reg_addr == SPC_OFS_STATUS) |=> (reg_rdata[SPC_ST_RX] == $past(pause_rx_en) &&
                                         reg_rdata[SPC_ST_TX] == $past(pause_tx_en));
  endproperty
  a_status: assert property (p_status) else $error("status does not show active pause"); // see [R05] see [R06]

  property p_maxlen;
    @(posedge mclk) disable iff (rst)
      maxlen_reg >= SPC_LEN_MIN && maxlen_reg <= SPC_LEN_MAX;
  endproperty
  a_maxlen: assert property (p_maxlen) else $error("maximum frame length out of range"); // see [R11]

  property p_oversize;
    @(posedge mclk) disable iff (rst)
      (rx_valid && rx_state_reg == SPC_RX_DROP) |=> !fwd_valid;
  endproperty
  a_oversize: assert property (p_oversize) else $error("oversize frame bytes forwarded"); // see [R13]

endmodule
